/* File: slm_cfg.svh */
`ifndef SLM_CFG_SVH
`define SLM_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SLM_REG_CTRL      6'h00
`define SLM_REG_NODE_HDR  6'h04
`define SLM_REG_TX_LEN    6'h08
`define SLM_REG_TX_DATA   6'h0C
`define SLM_REG_TIMEOUT   6'h10
`define SLM_REG_SETUP     6'h14
`define SLM_REG_RX_LEN    6'h18
`define SLM_REG_RX_DATA   6'h1C
`define SLM_REG_STAT_LO   6'h20
`define SLM_REG_STAT_HI   6'h2C

// ----------------------------------------------------------------
// Control and node/header register fields
// ----------------------------------------------------------------
`define SLM_CTRL_START    0
`define SLM_CTRL_PORT_LO  1
`define SLM_CTRL_PORT_HI  2
`define SLM_CTRL_CLR_REF  3
`define SLM_HDR_LO        16
`define SLM_HDR_HI        31

// ----------------------------------------------------------------
// Sizes and codes
// ----------------------------------------------------------------
`define SLM_PORTS         4
`define SLM_TX_MAX        123
`define SLM_FRAME_MAX     131
`define SLM_FRAME_LIMIT   8'h83
`define SLM_PROTO_MASTER  4'h6
`define SLM_TIMEOUT_RST   16'h01F4
`define SLM_CH_AT         8'h40
`define SLM_CH_STAR       8'h2A
`define SLM_HDR_UNDEF     16'h4943
`define SLM_EC_FCS        8'h13
`define SLM_EC_FORMAT     8'h14
`define SLM_EC_LENGTH     8'h18
`define SLM_ST_TIMEOUT    9'h100
`define SLM_POS_HDR       8'h05
`define SLM_POS_DATA      8'h07
`define SLM_RX_MIN_STAR   8'h09

`endif

/* File: slm_pkg.sv */
`include "slm_cfg.svh"

package slm_pkg;

	typedef enum logic [1:0] {
		st_idle,
		st_send,
		st_recv
	} slm_fsm_t;

	typedef struct packed {
		slm_fsm_t                            st;
		logic                                wreq;
		logic [31:0]                         rdata;
		logic [1:0]                          port;
		logic [6:0]                          node;
		logic [15:0]                         hdr;
		logic [6:0]                          txlen;
		logic [6:0]                          txwp;
		logic [`SLM_TX_MAX-1:0][7:0]         txbuf;
		logic [15:0]                         tmo;
		logic [15:0]                         setup;
		logic [`SLM_PORTS-1:0][8:0]          stat;
		logic                                refused;
		logic [7:0]                          pos;
		logic [7:0]                          frame_check_chars;
		logic [7:0]                          b1;
		logic [7:0]                          b2;
		logic                                ovf;
		logic [`SLM_FRAME_MAX-1:0][7:0]      rxbuf;
		logic [7:0]                          rxlen;
		logic [7:0]                          rxrp;
		logic [15:0]                         tcnt;
		logic                                tx_valid;
		logic [7:0]                          tx_data;
	} slm_regs_t;

endpackage

/* File: slm_link_master.sv */
// The Avalon-MM register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

`include "slm_cfg.svh"

// Overview of operation
// - Error-free command and reply leaves the port status at zero.
// - Slave end code 01, refused in run mode, goes into status.
// - Bad frame check in a reply gives end code 13.
// - Malformed, split or too short reply gives end code 14.
// - Slave end code 15, data out of range, goes into status.
// - Frames over 131 bytes give end code 18; we never send more.
// - Slave end code 19, no access rights, goes into status.
// - Slave end code 21, slave processor error, goes into status.
// - A timeout bounds send plus reply, then writes status and frees.
// - One timeout setting serves every command and every port.
// - No reply within the timeout sets status bit 8.
// - Each serial port keeps its own last-transfer status.
// - Errors found here in a reply go into the port status.
// - A port runs as master only with protocol selector 6.
// - Frame: at-sign, two node digits, header, payload, check, asterisk.
// - Each command goes out as one single frame.
module slm_link_master (
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire logic        servo_tick,
	input  wire logic [5:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	output logic      [7:0]  tx_data,
	output logic             tx_valid,
	input  wire logic        tx_ready,
	output logic      [1:0]  tx_port,
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_valid
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] hex_char(input logic [3:0] v);
		hex_char = (v < 4'hA) ? (8'h30 + {4'h0, v}) : (8'h37 + {4'h0, v});
	endfunction

	function automatic logic [3:0] dec_tens(input logic [6:0] v);
		logic [6:0] t;
		t = v / 7'h0A;
		dec_tens = t[3:0];
	endfunction

	function automatic logic [3:0] dec_ones(input logic [6:0] v);
		logic [6:0] o;
		o = v % 7'h0A;
		dec_ones = o[3:0];
	endfunction

	slm_pkg::slm_regs_t s;
	slm_pkg::slm_regs_t next_s;

	logic        acc;
	logic        acc_wr;
	logic        acc_rd;
	logic [31:0] rd_val;
	logic [7:0]  fcs_pos;
	logic [7:0]  end_pos;
	logic [7:0]  tx_byte;
	logic [7:0]  tx_idx;
	logic [7:0]  rx_calc;
	logic [7:0]  code;
	logic [7:0]  node_tens_ch;
	logic [7:0]  node_ones_ch;
	logic [3:0]  port_proto;
	logic [7:0]  rx_idx;
	logic [15:0] tcnt_inc;

	// ----------------------------------------------------------------
	// Register read mux
	// ----------------------------------------------------------------
	always_comb begin
		rx_idx = s.rxrp + `SLM_POS_DATA;
		rd_val = 32'h0000_0000;
		if (avs_address == `SLM_REG_CTRL) begin
			rd_val = {30'h0, s.refused, s.st != slm_pkg::st_idle};
		end else if (avs_address == `SLM_REG_NODE_HDR) begin
			rd_val = {s.hdr, 9'h000, s.node};
		end else if (avs_address == `SLM_REG_TX_LEN) begin
			rd_val = {25'h0, s.txlen};
		end else if (avs_address == `SLM_REG_TIMEOUT) begin
			rd_val = {16'h0000, s.tmo};
		end else if (avs_address == `SLM_REG_SETUP) begin
			rd_val = {16'h0000, s.setup};
		end else if (avs_address == `SLM_REG_RX_LEN) begin
			rd_val = {24'h0, s.rxlen};
		end else if (avs_address == `SLM_REG_RX_DATA) begin
			// Past the end of the reply buffer a read returns zero
			if (rx_idx < `SLM_FRAME_LIMIT) begin
				rd_val = {24'h0, s.rxbuf[rx_idx]};
			end
		end else if (avs_address >= `SLM_REG_STAT_LO && avs_address <= `SLM_REG_STAT_HI) begin
			// Each port keeps only the outcome of its last transfer
			rd_val = {23'h0, s.stat[avs_address[3:2]]};
		end
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		acc = !s.wreq && (avs_read || avs_write);
		acc_wr = acc && avs_write && (avs_byteenable != 4'h0);
		acc_rd = acc && avs_read;
		fcs_pos = {1'b0, s.txlen} + `SLM_POS_HDR;
		end_pos = fcs_pos + 8'h02;
		tx_idx = s.pos - `SLM_POS_HDR;
		node_tens_ch = hex_char(dec_tens(s.node));
		node_ones_ch = hex_char(dec_ones(s.node));
		// Selector nibble of the port named in this very write
		port_proto = s.setup[{avs_writedata[`SLM_CTRL_PORT_HI:`SLM_CTRL_PORT_LO], 2'b00} +: 4];
		rx_calc = s.frame_check_chars ^ s.b1 ^ s.b2;
		tcnt_inc = s.tcnt + 16'h0001;
		code = 8'h00;
		tx_byte = `SLM_CH_STAR;

		// One wait state, then the answer; reads are captured here
		if (s.wreq && (avs_read || avs_write)) begin
			next_s.wreq = 1'b0;
			next_s.rdata = rd_val;
		end else begin
			next_s.wreq = 1'b1;
		end

		if (acc_rd && avs_address == `SLM_REG_RX_DATA) begin
			next_s.rxrp = s.rxrp + 8'h01;
		end

		if (acc_wr) begin
			if (avs_address == `SLM_REG_CTRL) begin
				if (avs_writedata[`SLM_CTRL_CLR_REF]) begin
					next_s.refused = 1'b0;
				end
				if (avs_writedata[`SLM_CTRL_START]) begin
					// Start only when idle and the named port is set up for master use
					if (s.st == slm_pkg::st_idle && port_proto == `SLM_PROTO_MASTER) begin
						next_s.port = avs_writedata[`SLM_CTRL_PORT_HI:`SLM_CTRL_PORT_LO];
						next_s.st = slm_pkg::st_send;
						next_s.pos = 8'h00;
						next_s.frame_check_chars = 8'h00;
						next_s.tcnt = 16'h0000;
					end else begin
						next_s.refused = 1'b1;
					end
				end
			end else if (avs_address == `SLM_REG_NODE_HDR) begin
				next_s.node = avs_writedata[6:0];
				next_s.hdr = avs_writedata[`SLM_HDR_HI:`SLM_HDR_LO];
			end else if (avs_address == `SLM_REG_TX_LEN) begin
				// Payload capped so a frame never exceeds the limit
				next_s.txlen = (avs_writedata[6:0] > 7'(`SLM_TX_MAX)) ?
					7'(`SLM_TX_MAX) : avs_writedata[6:0];
				next_s.txwp = 7'h00;
			end else if (avs_address == `SLM_REG_TX_DATA) begin
				if (s.txwp < 7'(`SLM_TX_MAX)) begin
					next_s.txbuf[s.txwp] = avs_writedata[7:0];
					next_s.txwp = s.txwp + 7'h01;
				end
			end else if (avs_address == `SLM_REG_TIMEOUT) begin
				next_s.tmo = avs_writedata[15:0];
			end else if (avs_address == `SLM_REG_SETUP) begin
				next_s.setup = avs_writedata[15:0];
			end else if (avs_address == `SLM_REG_RX_LEN) begin
				next_s.rxrp = 8'h00;
			end
		end

		case (s.st)
			slm_pkg::st_send: begin
				if (s.pos == 8'h00) begin
					tx_byte = `SLM_CH_AT;
				end else if (s.pos == 8'h01) begin
					tx_byte = node_tens_ch;
				end else if (s.pos == 8'h02) begin
					tx_byte = node_ones_ch;
				end else if (s.pos == 8'h03) begin
					tx_byte = s.hdr[15:8];
				end else if (s.pos == 8'h04) begin
					tx_byte = s.hdr[7:0];
				end else if (s.pos < fcs_pos) begin
					tx_byte = s.txbuf[tx_idx[6:0]];
				end else if (s.pos == fcs_pos) begin
					tx_byte = hex_char(s.frame_check_chars[7:4]);
				end else if (s.pos == fcs_pos + 8'h01) begin
					tx_byte = hex_char(s.frame_check_chars[3:0]);
				end
				// Next byte loads as the current one is taken: no idle gap
				if (!s.tx_valid || tx_ready) begin
					if (s.pos <= end_pos) begin
						next_s.tx_valid = 1'b1;
						next_s.tx_data = tx_byte;
						next_s.pos = s.pos + 8'h01;
						if (s.pos < fcs_pos) begin
							next_s.frame_check_chars = s.frame_check_chars ^ tx_byte;
						end
					end else begin
						// Whole command went out in one frame; now await the reply
						next_s.tx_valid = 1'b0;
						next_s.st = slm_pkg::st_recv;
						next_s.pos = 8'h00;
						next_s.frame_check_chars = 8'h00;
						next_s.b1 = 8'h00;
						next_s.b2 = 8'h00;
						next_s.ovf = 1'b0;
					end
				end
			end
			slm_pkg::st_recv: begin
				if (rx_valid && rx_data == `SLM_CH_STAR) begin
					if (s.ovf || s.pos >= `SLM_FRAME_LIMIT) begin
						code = `SLM_EC_LENGTH;
					end else if (s.pos < `SLM_RX_MIN_STAR) begin
						code = `SLM_EC_FORMAT;
					end else if ({s.b1, s.b2} != {hex_char(rx_calc[7:4]), hex_char(rx_calc[3:0])}) begin
						code = `SLM_EC_FCS;
					end else if (s.rxbuf[0] != `SLM_CH_AT || s.rxbuf[1] != node_tens_ch
						|| s.rxbuf[2] != node_ones_ch || {s.rxbuf[3], s.rxbuf[4]} != s.hdr
						|| {s.rxbuf[3], s.rxbuf[4]} == `SLM_HDR_UNDEF) begin
						// Wrong node, echo header or undefined-command reply
						code = `SLM_EC_FORMAT;
					end else begin
						// Slave end code digits copied as two BCD nibbles
						code = {s.rxbuf[5][3:0], s.rxbuf[6][3:0]};
					end
					next_s.stat[s.port] = {1'b0, code};
					next_s.rxlen = (code == 8'h00) ? (s.pos - `SLM_RX_MIN_STAR) : 8'h00;
					next_s.rxrp = 8'h00;
					next_s.st = slm_pkg::st_idle;
				end else if (rx_valid) begin
					if (s.pos < `SLM_FRAME_LIMIT) begin
						next_s.rxbuf[s.pos] = rx_data;
					end else begin
						// Dropped but remembered, so the length error still shows
						next_s.ovf = 1'b1;
					end
					if (s.pos != 8'hFF) begin
						next_s.pos = s.pos + 8'h01;
					end
					next_s.frame_check_chars = s.frame_check_chars ^ rx_data;
					next_s.b1 = s.b2;
					next_s.b2 = rx_data;
				end
			end
			default: begin
			end
		endcase

		// Timeout covers sending and receiving alike; a reply in the
		// very last cycle still counts as arrived
		if (s.st != slm_pkg::st_idle && next_s.st != slm_pkg::st_idle && servo_tick) begin
			next_s.tcnt = tcnt_inc;
			if (tcnt_inc >= s.tmo) begin
				next_s.stat[s.port] = `SLM_ST_TIMEOUT;
				next_s.st = slm_pkg::st_idle;
				next_s.tx_valid = 1'b0;
				next_s.rxlen = 8'h00;
			end
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			s <= '0;
			// Waitrequest idles high so no access slips through reset
			s.wreq <= 1'b1;
			s.tmo <= `SLM_TIMEOUT_RST;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign avs_readdata = s.rdata;
	assign avs_waitrequest = s.wreq;
	assign tx_data = s.tx_data;
	assign tx_valid = s.tx_valid;
	assign tx_port = s.port;

endmodule

`default_nettype wire

/* File: slm_link_master_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module slm_link_master_checker (
	input wire logic       mclk,
	input wire logic       sys_rst,
	input wire logic       servo_tick,
	input wire logic       avs_read,
	input wire logic       avs_write,
	input wire logic       avs_waitrequest,
	input wire logic [7:0] tx_data,
	input wire logic       tx_valid,
	input wire logic       tx_ready,
	input wire logic [1:0] tx_port
);
	logic [7:0] nb;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);
	// Bytes taken so far in this frame
	always_ff @(posedge mclk) begin
		if (sys_rst || !tx_valid)
			nb <= 8'h00;
		else if (tx_ready)
			nb <= nb + 8'h01;
	end
	a_wait_one:
	assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("answer late");
	a_wait_short:
	assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("answer too long");
	a_idle_wait:
	assert property (!(avs_read || avs_write) |=> avs_waitrequest)
		else $error("answer without request");
	a_wait_req:
	assert property (!avs_waitrequest |-> avs_read || avs_write)
		else $error("request gone at answer");
	a_tx_hold:
	assert property (tx_valid && !tx_ready |=>
		(tx_valid && $stable(tx_data) && $stable(tx_port)) || (!tx_valid && $past(servo_tick)))
		else $error("tx byte not held");
	a_frame_start:
	assert property ($rose(tx_valid) |-> tx_data == 8'h40)
		else $error("frame start wrong");
	a_star_drop:
	assert property (tx_valid && tx_ready && tx_data == 8'h2A && nb >= 8'd7 |=> !tx_valid)
		else $error("send past frame end");
	a_frame_len:
	assert property (tx_valid && tx_ready |-> nb < 8'd131)
		else $error("frame too long");
endmodule
bind slm_link_master slm_link_master_checker u_slm_link_master_checker (
	.mclk(mclk), .sys_rst(sys_rst), .servo_tick(servo_tick),
	.avs_read(avs_read), .avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest), .tx_data(tx_data), .tx_valid(tx_valid),
	.tx_ready(tx_ready), .tx_port(tx_port)
);
`default_nettype wire

/* File: slm_slave_model.sv */
`timescale 1ns/100ps
`default_nettype none
module slm_slave_model (
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	output logic            tx_ready,
	output logic      [7:0] rx_data,
	output logic            rx_valid,
	input  wire logic [7:0] ec,
	input  wire logic [2:0] flags
);
	logic [6:0][7:0] cap;
	logic            mon;
	logic [7:0]      rc;
	logic [9:0][7:0] rep;
	logic [7:0]      x;
	int              ti;
	int              ri;
	int              gap;
	function automatic logic [7:0] hx(input logic [3:0] v);
		return (v < 4'hA) ? {4'h3, v} : 8'h37 + v;
	endfunction
	// Ready every other cycle, so the sender must hold bytes
	always @(posedge mclk) begin
		tx_ready <= ~tx_ready | sys_rst;
		rx_valid <= 1'b0;
		rx_data <= ~rx_data;
		if (sys_rst) begin
			ti = 0;
			ri = -1;
			mon = 1'b0;
			rx_data <= 8'h00;
		end else if (tx_valid && tx_ready) begin
			if (ti < 7)
				cap[ti] = tx_data;
			ti = (tx_data == 8'h2A) ? 0 : ti + 1;
			if (tx_data == 8'h2A && !flags[0]) begin
				// Memory writes are refused while the slave sits in run mode
				rc = (cap[3] == 8'h57 && !mon) ? 8'h01 : ec;
				if ({cap[3], cap[4]} == 16'h5343)
					mon = ({cap[5], cap[6]} == 16'h3032);
				rep[9:3] = {8'h40, cap[1], cap[2],
					flags[1] ? 16'h4943 : {cap[3], cap[4]},
					4'h3, rc[7:4], 4'h3, rc[3:0]};
				x = 8'h00;
				for (int i = 3; i < 10; i++)
					x ^= rep[i];
				rep[2:0] = {hx(x[7:4]), hx(x[3:0] ^ {3'h0, flags[2]}), 8'h2A};
				ri = 9;
				gap = 0;
			end
		end else if (ri >= 0 && gap == 2) begin
			rx_data <= rep[ri];
			rx_valid <= 1'b1;
			ri--;
			gap = 0;
		end else
			gap = gap + 1;
	end
endmodule
`default_nettype wire

/* File: serial_link_master_status_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module serial_link_master_status_tb_top;
	logic        mclk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        servo_tick = 1'b0;
	logic [5:0]  avs_address = 6'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [7:0]  tx_data;
	logic        tx_valid;
	logic        tx_ready;
	logic [1:0]  tx_port;
	logic [7:0]  rx_data;
	logic        rx_valid;
	logic [7:0]  ec = 8'h00;
	logic [2:0]  flags = 3'h0;
	logic [7:0]  txq[$];
	logic [7:0]  codes[5] = '{8'h00, 8'h01, 8'h15, 8'h19, 8'h21};
	logic [79:0] frame = "@13SC0250*";
	logic [79:0] frame_wd = "@13WD0253*";
	int          cyc = 0;
	int          bad_count = 0;
	int          total_checks = 0;
	slm_link_master u_slm_link_master (
		.mclk(mclk), .sys_rst(sys_rst), .servo_tick(servo_tick),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hF),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.tx_port(tx_port), .rx_data(rx_data), .rx_valid(rx_valid)
	);
	slm_slave_model u_slm_slave_model (
		.mclk(mclk), .sys_rst(sys_rst), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
		.ec(ec), .flags(flags)
	);
	always #5 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc++;
		servo_tick <= (cyc % 4 == 3);
		if (tx_valid && tx_ready)
			txq.push_back(tx_data);
		if (cyc == 20000) begin
			bad_count++;
			$display("ERROR %0t run timed out", $time);
			close_out();
		end
	end
	task automatic close_out();
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Extra idle edge at the end keeps back-to-back calls from double driving
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
			output logic [31:0] q);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0)
			@(posedge mclk);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask
	task automatic xfer(input logic [1:0] p, input logic [7:0] e, input logic [2:0] f,
			input logic [31:0] exp, input logic [79:0] fr);
		int          t0;
		logic [31:0] q;
		ec <= e;
		flags <= f;
		t0 = cyc;
		wr(6'h00, {28'h0, 1'b0, p, 1'b1});
		q = 32'h1;
		while (q[0] !== 1'b0)
			bus(1'b0, 6'h00, 32'h0, q);
		if (f[0])
			chk(32'((cyc - t0) inside {[76:100]}), 32'h1);
		rd_chk(6'h20 | {2'h0, p, 2'h0}, exp);
		chk({30'h0, tx_port}, {30'h0, p});
		for (int i = 0; i < 10; i++)
			chk({24'h0, txq[i]}, {24'h0, fr[79-8*i -: 8]});
		chk(txq.size(), 32'd10);
		txq.delete();
	endtask
	initial begin
		repeat (8) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		rd_chk(6'h10, 32'h1F4);
		rd_chk(6'h30, 32'h0);
		wr(6'h00, 32'h3);
		rd_chk(6'h00, 32'h2);
		wr(6'h00, 32'h8);
		rd_chk(6'h00, 32'h0);
		wr(6'h14, 32'h660);
		wr(6'h04, 32'h5744000D);
		wr(6'h08, 32'h2);
		wr(6'h0C, 32'h30);
		wr(6'h0C, 32'h32);
		xfer(2'h1, 8'h00, 3'h0, 32'h01, frame_wd);
		wr(6'h04, 32'h5343000D);
		foreach (codes[i])
			xfer(2'h1, codes[i], 3'h0, {24'h0, codes[i]}, frame);
		wr(6'h04, 32'h5744000D);
		xfer(2'h1, 8'h00, 3'h0, 32'h00, frame_wd);
		xfer(2'h1, 8'h00, 3'h4, 32'h13, frame_wd);
		xfer(2'h1, 8'h00, 3'h2, 32'h14, frame_wd);
		wr(6'h10, 32'h14);
		xfer(2'h2, 8'h00, 3'h1, 32'h100, frame_wd);
		rd_chk(6'h24, 32'h14);
		rd_chk(6'h20, 32'h0);
		close_out();
	end
endmodule
`default_nettype wire
